// [hdl/cim_counter_input.sv]
// Counter input unit: edge count, pulse width and pulse measurement
// Assumes AXI4-Lite master on mclk; pins are asynchronous; stream sink on mclk
`timescale 1ns/1ps
`default_nettype none
`include "cim_regs.svh"

module cim_counter_input #(
	parameter int CNT_W = 32,
	parameter int FIFO_DEPTH = 16,
	parameter int LVL_W = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire cim_pkg::cim_pins_t pins,
	output logic [CNT_W-1:0] strm_data,
	output logic strm_valid,
	input wire logic strm_ready
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	cim_pkg::cim_pins_t pins_s;
	cim_pkg::cim_pins_t pins_q;

	cim_sync #(.WIDTH(5)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.async_in(pins),
		.sync_out(pins_s)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pins_q <= '0;
		end else if (ce) begin
			pins_q <= pins_s;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] ctrl_q;
	cim_pkg::cim_cfg_t cfg;
	assign cfg = {ctrl_q[`CIM_CTRL_FIRST_LOW], ctrl_q[`CIM_CTRL_SCLK_FALL],
		ctrl_q[`CIM_CTRL_GATE_LOW], ctrl_q[`CIM_CTRL_PAUSE_LOW], ctrl_q[`CIM_CTRL_PAUSE_EN],
		ctrl_q[`CIM_CTRL_DIR_LSB +: 2], ctrl_q[`CIM_CTRL_SRC_FALL],
		ctrl_q[`CIM_CTRL_MODE_LSB +: 3]};

	logic armed_q;
	logic overrun_q;
	logic done_q;
	logic fifo_ovf_q;
	logic [CNT_W-1:0] count_q;

	logic aw_hold_q;
	logic w_hold_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic rd_go;
	logic fifo_pop_sw;

	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_q)
					`CIM_OFF_CTRL, `CIM_OFF_CMD: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	logic cmd_arm;
	logic cmd_disarm;
	logic cmd_clr;
	assign cmd_arm = wr_go && awaddr_q == `CIM_OFF_CMD && wstrb_q[0] && wdata_q[`CIM_CMD_ARM];
	assign cmd_disarm = wr_go && awaddr_q == `CIM_OFF_CMD && wstrb_q[0]
		&& wdata_q[`CIM_CMD_DISARM];
	assign cmd_clr = wr_go && awaddr_q == `CIM_OFF_CMD && wstrb_q[0]
		&& wdata_q[`CIM_CMD_CLR_OVR];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `CIM_CTRL_RESET;
		end else if (ce && wr_go && awaddr_q == `CIM_OFF_CTRL && !armed_q) begin
			ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q);
		end
	end

	// ------------------------------------------------------------
	// Edge detection and arming
	// ------------------------------------------------------------
	logic src_edge;
	logic sclk_edge;
	logic gate_act;
	logic gate_act_prev;
	logic gate_rise;
	logic gate_fall;
	logic pause_on;
	logic hw_arm_edge;
	logic start_q;
	logic phase_q;

	assign src_edge = cfg.src_fall ? (pins_q.source && !pins_s.source)
		: (!pins_q.source && pins_s.source);
	assign sclk_edge = cfg.sclk_fall ? (pins_q.sclk && !pins_s.sclk)
		: (!pins_q.sclk && pins_s.sclk);
	assign gate_act = pins_s.gate ^ cfg.gate_low;
	assign gate_act_prev = pins_q.gate ^ cfg.gate_low;
	assign gate_rise = gate_act && !gate_act_prev;
	assign gate_fall = !gate_act && gate_act_prev;
	assign pause_on = cfg.pause_en && (pins_s.gate ^ cfg.pause_low);
	assign hw_arm_edge = ctrl_q[`CIM_CTRL_HW_ARM] && pins_s.hw_arm && !pins_q.hw_arm;

	logic is_edge;
	logic is_pm;
	logic is_single;
	logic is_sampled;
	logic is_implicit;
	assign is_edge = cfg.mode == cim_pkg::CIM_EDGE_DEMAND || cfg.mode == cim_pkg::CIM_EDGE_SAMPLED;
	assign is_pm = cfg.mode == cim_pkg::CIM_PM_SINGLE || cfg.mode == cim_pkg::CIM_PM_IMPLICIT
		|| cfg.mode == cim_pkg::CIM_PM_SAMPLED;
	assign is_single = cfg.mode == cim_pkg::CIM_PW_SINGLE || cfg.mode == cim_pkg::CIM_PM_SINGLE;
	assign is_sampled = cfg.mode == cim_pkg::CIM_PW_SAMPLED
		|| cfg.mode == cim_pkg::CIM_PM_SAMPLED;
	assign is_implicit = cfg.mode == cim_pkg::CIM_PW_IMPLICIT
		|| cfg.mode == cim_pkg::CIM_PM_IMPLICIT;

	logic arm_ev;
	assign arm_ev = (cmd_arm || hw_arm_edge) && !armed_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (ce) begin
			if (cmd_disarm) begin
				armed_q <= 1'b0;
			end else if (arm_ev) begin
				armed_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Measurement core
	// ------------------------------------------------------------
	logic [CNT_W-1:0] hi_last_q;
	logic [CNT_W-1:0] lo_last_q;
	logic have_q;
	logic push;
	logic [CNT_W-1:0] push_data;
	logic push2_q;
	logic [CNT_W-1:0] push2_data_q;
	logic meas_end;
	logic start_edge;
	logic [CNT_W-1:0] step_cnt;

	// Pulse measurement starts on the chosen phase; width starts on the active edge
	assign start_edge = is_pm ? (cfg.first_low ? gate_fall : gate_rise) : gate_rise;
	assign meas_end = is_pm ? (gate_rise || gate_fall) : gate_fall;
	assign step_cnt = src_edge ? count_q + CNT_W'(1) : count_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			start_q <= 1'b0;
			phase_q <= 1'b0;
			done_q <= 1'b0;
			hi_last_q <= '0;
			lo_last_q <= '0;
			have_q <= 1'b0;
		end else if (ce) begin
			if (arm_ev) begin
				count_q <= '0;
				start_q <= 1'b0;
				done_q <= 1'b0;
				have_q <= 1'b0;
			end else if (armed_q && is_edge) begin
				if (src_edge && !pause_on) begin
					case (cfg.dir)
						cim_pkg::CIM_DIR_UP: count_q <= count_q + CNT_W'(1);
						cim_pkg::CIM_DIR_DOWN: count_q <= count_q - CNT_W'(1);
						cim_pkg::CIM_DIR_PIN: count_q <= pins_s.dir ? count_q + CNT_W'(1)
							: count_q - CNT_W'(1);
						default: count_q <= count_q;
					endcase
				end
			end else if (armed_q && !done_q) begin
				// Cleared first so a pulse ending on the sample edge still counts
				if (sclk_edge && is_sampled) begin
					have_q <= 1'b0;
				end
				if (!start_q) begin
					if (start_edge) begin
						start_q <= 1'b1;
						phase_q <= gate_act;
						count_q <= '0;
					end
				end else if (meas_end) begin
					count_q <= '0;
					phase_q <= gate_act;
					if (phase_q || !is_pm) begin
						hi_last_q <= count_q;
					end else begin
						lo_last_q <= count_q;
					end
					if (!is_pm || phase_q == cfg.first_low) begin
						have_q <= 1'b1;
					end
					// Single pulse mode stops after the second phase, single width mode after the first
					if (is_single && (!is_pm || phase_q == cfg.first_low)) begin
						done_q <= 1'b1;
						start_q <= 1'b0;
					end
				end else if (is_pm || gate_act) begin
					count_q <= step_cnt;
				end
			end
		end
	end

	always_comb begin
		push = 1'b0;
		push_data = count_q;
		if (armed_q && !arm_ev && ce) begin
			if (cfg.mode == cim_pkg::CIM_EDGE_SAMPLED && sclk_edge) begin
				push = 1'b1;
			end else if (is_sampled && sclk_edge && have_q) begin
				push = 1'b1;
				push_data = hi_last_q;
			end else if ((is_implicit || is_single) && start_q && !done_q && meas_end) begin
				push = 1'b1;
			end
		end
	end

	// Sampled pulse measurement emits the low count right after the high one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			push2_q <= 1'b0;
			push2_data_q <= '0;
		end else if (ce) begin
			push2_q <= push && cfg.mode == cim_pkg::CIM_PM_SAMPLED;
			push2_data_q <= lo_last_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (ce) begin
			if (armed_q && is_sampled && sclk_edge && !have_q) begin
				overrun_q <= 1'b1;
			end else if (cmd_clr || cmd_disarm) begin
				overrun_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Capture FIFO and stream
	// ------------------------------------------------------------
	logic [CNT_W-1:0] mem_q [FIFO_DEPTH];
	logic [LVL_W-1:0] wr_ptr_q;
	logic [LVL_W-1:0] rd_ptr_q;
	logic [LVL_W-1:0] level;
	logic fifo_wr;
	logic [CNT_W-1:0] fifo_wdata;
	logic fifo_rd;

	assign level = wr_ptr_q - rd_ptr_q;
	assign fifo_wr = (push || push2_q) && level != LVL_W'(FIFO_DEPTH);
	assign fifo_wdata = push ? push_data : push2_data_q;
	assign fifo_rd = level != '0 && (!strm_valid || strm_ready || fifo_pop_sw);

	always_ff @(posedge mclk) begin
		if (ce && fifo_wr) begin
			mem_q[wr_ptr_q[LVL_W-2:0]] <= fifo_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fifo_ovf_q <= 1'b0;
			strm_valid <= 1'b0;
			strm_data <= '0;
		end else if (ce) begin
			if (fifo_wr) begin
				wr_ptr_q <= wr_ptr_q + LVL_W'(1);
			end
			if ((push || push2_q) && !fifo_wr) begin
				fifo_ovf_q <= 1'b1;
			end else if (cmd_clr) begin
				fifo_ovf_q <= 1'b0;
			end
			if (fifo_rd) begin
				rd_ptr_q <= rd_ptr_q + LVL_W'(1);
				strm_valid <= 1'b1;
				strm_data <= mem_q[rd_ptr_q[LVL_W-2:0]];
			end else if (strm_ready || fifo_pop_sw) begin
				strm_valid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign fifo_pop_sw = rd_go && s_axi_araddr == `CIM_OFF_FIFO && strm_valid;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`CIM_OFF_CTRL: s_axi_rdata <= ctrl_q;
					`CIM_OFF_STAT: s_axi_rdata <= {28'h0, fifo_ovf_q, done_q, overrun_q, armed_q};
					`CIM_OFF_COUNT: s_axi_rdata <= 32'(count_q);
					`CIM_OFF_FIFO: s_axi_rdata <= strm_valid ? 32'(strm_data) : 32'h0000_0000;
					`CIM_OFF_LEVEL: s_axi_rdata <= 32'(level);
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// [hdl/cim_regs.svh]
// Register offsets, field positions, reset values for the counter input unit
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef CIM_REGS_SVH
`define CIM_REGS_SVH

`define CIM_OFF_CTRL 12'h000
`define CIM_OFF_CMD 12'h004
`define CIM_OFF_STAT 12'h008
`define CIM_OFF_COUNT 12'h00C
`define CIM_OFF_FIFO 12'h010
`define CIM_OFF_LEVEL 12'h014

`define CIM_CTRL_MODE_LSB 0
`define CIM_CTRL_SRC_FALL 4
`define CIM_CTRL_DIR_LSB 5
`define CIM_CTRL_PAUSE_EN 7
`define CIM_CTRL_PAUSE_LOW 8
`define CIM_CTRL_GATE_LOW 9
`define CIM_CTRL_SCLK_FALL 10
`define CIM_CTRL_FIRST_LOW 11
`define CIM_CTRL_HW_ARM 12
`define CIM_CTRL_RESET 32'h0000_0000

`define CIM_CMD_ARM 0
`define CIM_CMD_DISARM 1
`define CIM_CMD_CLR_OVR 2

`define CIM_STAT_ARMED 0
`define CIM_STAT_OVERRUN 1
`define CIM_STAT_DONE 2
`define CIM_STAT_FIFO_OVF 3

`endif

// [hdl/cim_pkg.sv]
// Types shared by the counter input unit
// Assumes the register header is included by the files that need offsets
package cim_pkg;

	typedef enum logic [2:0] {
		CIM_EDGE_DEMAND,
		CIM_EDGE_SAMPLED,
		CIM_PW_SINGLE,
		CIM_PW_IMPLICIT,
		CIM_PW_SAMPLED,
		CIM_PM_SINGLE,
		CIM_PM_IMPLICIT,
		CIM_PM_SAMPLED
	} cim_mode_t;

	typedef enum logic [1:0] {
		CIM_DIR_UP,
		CIM_DIR_DOWN,
		CIM_DIR_PIN
	} cim_dir_t;

	typedef struct packed {
		logic first_low;
		logic sclk_fall;
		logic gate_low;
		logic pause_low;
		logic pause_en;
		cim_dir_t dir;
		logic src_fall;
		cim_mode_t mode;
	} cim_cfg_t;

	typedef struct packed {
		logic source;
		logic gate;
		logic dir;
		logic sclk;
		logic hw_arm;
	} cim_pins_t;

endpackage

// [hdl/cim_sync.sv]
// Two-stage synchroniser for a group of asynchronous pins
// Assumes inputs are unrelated to mclk
`timescale 1ns/1ps
`default_nettype none

module cim_sync #(
	parameter int WIDTH = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// [sim/cim_counter_input_props.sv]
// Checker for the counter input unit ports
// Assumes binding to cim_counter_input; one clock domain, async reset rst
`timescale 1ns/1ps
`default_nettype none

module cim_counter_input_props #(
	parameter int CNT_W = 32
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [CNT_W-1:0] strm_data,
	input wire logic strm_valid,
	input wire logic strm_ready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_ready_return: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
		else $error("write channel not reopened");
	a_resp_after_take: assert property ($rose(s_axi_bvalid)
		|-> !$past(s_axi_awready) && !$past(s_axi_wready))
		else $error("response without taken request");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h018
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_strm_stands: assert property (strm_valid && !strm_ready && !s_axi_arvalid
		|=> strm_valid && $stable(strm_data))
		else $error("stream sample not held");
endmodule

bind cim_counter_input cim_counter_input_props #(.CNT_W(CNT_W)) u_props (
	.mclk(mclk),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.strm_data(strm_data),
	.strm_valid(strm_valid),
	.strm_ready(strm_ready)
);

`default_nettype wire

// [sim/cim_pin_model.sv]
// Far-side pins: source, gate, direction, sample clock and hardware arm
// Assumes pins are sampled on mclk and need 3 stable cycles per level
`timescale 1ns/1ps
`default_nettype none

module cim_pin_model (
	input wire logic mclk,
	output var cim_pkg::cim_pins_t pins
);
	initial pins = '0;
	// Each level stands five cycles so the synchroniser sees it
	task automatic lvl(input int k, input logic v);
		pins[k] <= v;
		repeat (5) @(posedge mclk);
	endtask
	task automatic src(input int n);
		repeat (n) begin
			lvl(4, 1'h1);
			lvl(4, 1'h0);
		end
	endtask
	task automatic sclk();
		lvl(1, 1'h1);
		lvl(1, 1'h0);
	endtask
endmodule

`default_nettype wire

// [sim/cim_counter_input_bench.sv]
// Bench for the counter input unit: register tasks, pin model, stream checks
// Assumes the register header offsets and a 250 MHz mclk
`timescale 1ns/1ps
`default_nettype none
`include "cim_regs.svh"

module cim_counter_input_bench;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, sry = 1'h0;
	logic skip = 1'h0;
	logic ce = 1'h1;
	logic [3:0] ws = 4'hF;
	logic awr, wrr, bv, arr, rv, sv;
	logic [11:0] awa = 12'h0, ara = 12'h0;
	logic [31:0] wd = 32'h0, rdt, sd;
	logic [1:0] br, rr, resp;
	logic [7:0] lf = 8'h1F;
	logic [31:0] rq[$], sq[$];
	int failures = 0, n_compared = 0, cyc = 0;
	cim_pkg::cim_pins_t pins;

	always #2 mclk = ~mclk;

	cim_counter_input u_cim_counter_input (
		.mclk(mclk), .rst(rst), .ce(ce),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdt), .s_axi_rresp(rr),
		.pins(pins), .strm_data(sd), .strm_valid(sv), .strm_ready(sry)
	);
	cim_pin_model u_cim_pin_model (.mclk(mclk), .pins(pins));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict();
		if (rq.size() || sq.size())
			failures++;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// AXI4-Lite master
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'h1;
		pw = 1'h1;
		awv <= 1'h1;
		wv <= 1'h1;
		awa <= a;
		wd <= d;
		bry <= 1'h1;
		while (pa || pw) begin
			@(posedge mclk);
			if (awr) awv <= 1'h0;
			if (wrr) wv <= 1'h0;
			pa = pa && !awr;
			pw = pw && !wrr;
		end
		do @(posedge mclk); while (!bv);
		bry <= 1'h0;
		resp = br;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		arv <= 1'h1;
		ara <= a;
		rry <= 1'h1;
		rq.push_back(e);
		do @(posedge mclk); while (!arr);
		arv <= 1'h0;
		do @(posedge mclk); while (!rv);
		rry <= 1'h0;
	endtask

	task automatic cfg(input logic [31:0] c);
		wr(`CIM_OFF_CMD, 32'h2);
		wr(`CIM_OFF_CTRL, c);
		wr(`CIM_OFF_CMD, 32'h1);
	endtask

	// Monitor: results are checked against the oldest note
	always @(posedge mclk) begin
		lf <= lfsr(lf);
		sry <= lf[0];
		if (rv && rry) cmp("rdata", rq.size() ? rq.pop_front() : 'x, rdt);
		if (sv && sry && !skip) cmp("stream", sq.size() ? sq.pop_front() : 'x, sd);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			give_verdict();
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		rd(`CIM_OFF_CTRL, 32'h0);
		rd(12'h020, 32'h0);
		wr(12'h020, 32'h5);
		cmp("bresp", 32'h2, {30'h0, resp});
		// Byte lanes honoured on control; command needs lane zero
		ws <= 4'h2;
		wr(`CIM_OFF_CTRL, 32'hFFFF_FFFF);
		wr(`CIM_OFF_CMD, 32'h1);
		ws <= 4'hF;
		rd(`CIM_OFF_CTRL, 32'h0000_FF00);
		rd(`CIM_OFF_STAT, 32'h0);
		cfg(32'h0);
		u_cim_pin_model.src(3);
		rd(`CIM_OFF_COUNT, 32'h3);
		u_cim_pin_model.src(2);
		rd(`CIM_OFF_COUNT, 32'h5);
		wr(`CIM_OFF_CTRL, 32'h10);
		rd(`CIM_OFF_CTRL, 32'h0);
		// Clock enable low freezes the count
		ce <= 1'h0;
		u_cim_pin_model.src(2);
		ce <= 1'h1;
		rd(`CIM_OFF_COUNT, 32'h5);
		cfg(32'h10);
		u_cim_pin_model.lvl(4, 1'h1);
		rd(`CIM_OFF_COUNT, 32'h0);
		u_cim_pin_model.lvl(4, 1'h0);
		rd(`CIM_OFF_COUNT, 32'h1);
		for (int k = 0; k < 4; k++) begin
			u_cim_pin_model.lvl(2, k == 3);
			cfg({25'h0, k == 3 ? 2'h2 : k[1:0], 5'h0});
			u_cim_pin_model.src(3);
			rd(`CIM_OFF_COUNT, (k == 0 || k == 3) ? 32'h3 : 32'hFFFF_FFFD);
		end
		u_cim_pin_model.lvl(3, 1'h0);
		cfg(32'h180);
		u_cim_pin_model.src(2);
		rd(`CIM_OFF_COUNT, 32'h0);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.src(2);
		rd(`CIM_OFF_COUNT, 32'h2);
		for (int f = 0; f < 2; f++) begin
			cfg(f ? 32'h401 : 32'h1);
			u_cim_pin_model.src(3);
			sq.push_back(32'h3);
			u_cim_pin_model.sclk();
			u_cim_pin_model.src(2);
			sq.push_back(32'h5);
			u_cim_pin_model.sclk();
		end
		cfg(32'h3);
		u_cim_pin_model.src(2);
		u_cim_pin_model.lvl(3, 1'h0);
		for (int p = 4; p > 0; p -= 3) begin
			u_cim_pin_model.lvl(3, 1'h1);
			u_cim_pin_model.src(p);
			sq.push_back(p);
			u_cim_pin_model.lvl(3, 1'h0);
		end
		cfg(32'h2);
		for (int p = 0; p < 2; p++) begin
			u_cim_pin_model.lvl(3, 1'h1);
			u_cim_pin_model.src(3);
			if (p == 0) sq.push_back(32'h3);
			u_cim_pin_model.lvl(3, 1'h0);
		end
		cfg(32'h6);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.src(2);
		sq.push_back(32'h2);
		u_cim_pin_model.lvl(3, 1'h0);
		u_cim_pin_model.src(3);
		sq.push_back(32'h3);
		u_cim_pin_model.lvl(3, 1'h1);
		cfg(32'h4);
		u_cim_pin_model.lvl(3, 1'h0);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.src(3);
		u_cim_pin_model.lvl(3, 1'h0);
		sq.push_back(32'h3);
		u_cim_pin_model.sclk();
		while (sq.size()) @(posedge mclk);
		skip <= 1'h1;
		u_cim_pin_model.sclk();
		u_cim_pin_model.src(1);
		rd(`CIM_OFF_STAT, 32'h3);
		wr(`CIM_OFF_CMD, 32'h4);
		rd(`CIM_OFF_STAT, 32'h1);
		repeat (40) @(posedge mclk);
		skip <= 1'h0;
		// Single pulse starting with the low phase
		cfg(32'h805);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.lvl(3, 1'h0);
		u_cim_pin_model.src(2);
		sq.push_back(32'h2);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.src(3);
		sq.push_back(32'h3);
		u_cim_pin_model.lvl(3, 1'h0);
		u_cim_pin_model.src(1);
		u_cim_pin_model.lvl(3, 1'h1);
		rd(`CIM_OFF_STAT, 32'h5);
		// Sampled pulse with an active-low gate
		cfg(32'h207);
		u_cim_pin_model.lvl(3, 1'h0);
		u_cim_pin_model.src(2);
		u_cim_pin_model.lvl(3, 1'h1);
		u_cim_pin_model.src(3);
		u_cim_pin_model.lvl(3, 1'h0);
		sq.push_back(32'h2);
		sq.push_back(32'h3);
		u_cim_pin_model.sclk();
		wr(`CIM_OFF_CMD, 32'h2);
		wr(`CIM_OFF_CTRL, 32'h1000);
		u_cim_pin_model.lvl(0, 1'h1);
		u_cim_pin_model.lvl(0, 1'h0);
		rd(`CIM_OFF_STAT, 32'h1);
		repeat (60) @(posedge mclk);
		give_verdict();
	end
endmodule

`default_nettype wire
